/* File: pkg/pmc_pkg.sv */
// package for the power mode controller: register map, fields, reset values, states
package pmc_pkg;
    localparam logic [3:0]  ADDR_PLL_CONTROL = 4'h0;
    localparam logic [3:0]  ADDR_REG_CONTROL = 4'h4;
    localparam logic [3:0]  ADDR_MODE_REQ  = 4'h8;
    localparam logic [3:0]  ADDR_STATUS    = 4'hc;
    // pll control fields
    localparam int          PLL_BYPASS_BIT = 0;
    localparam int          PLL_OFF_BIT    = 1;
    localparam int          PLL_MSEL_LSB   = 8;
    localparam logic [5:0]  MSEL_RESET     = 6'h0a;
    localparam logic [15:0] PLL_CONTROL_RESET = 16'h0a00;
    // regulator control fields
    localparam int          VR_RATE_LSB    = 0;
    localparam int          VR_LEVEL_LSB   = 4;
    localparam int          VR_WAKE_LSB    = 8;
    localparam int          VR_SCKE_BIT    = 13;
    localparam int          VR_BYPASS_BIT  = 14;
    localparam logic [1:0]  RATE_OFF       = 2'h0;
    localparam logic [15:0] REG_CONTROL_RESET = 16'h00b3;
    localparam int          REG_STEP_MV    = 50;
    // wake enable bit order inside the five-bit wake field
    localparam int          WK_ETH = 0;
    localparam int          WK_CAN = 1;
    localparam int          WK_PIN = 2;
    localparam int          WK_RTC = 3;
    localparam int          WK_RST = 4;
    // software mode requests
    localparam logic [1:0]  REQ_SLEEP      = 2'h1;
    localparam logic [1:0]  REQ_DEEP       = 2'h2;
    localparam logic [1:0]  REQ_ACTIVE     = 2'h3;
    localparam logic [3:0]  RST_SEQ_CYCLES = 4'h8;

    typedef enum logic [2:0] {
        ST_FULLON = 3'b000,
        ST_ACTIVE = 3'b001,
        ST_SLEEP  = 3'b010,
        ST_DEEP   = 3'b011,
        ST_HIBER  = 3'b100
    } pmc_state_t;

    typedef struct packed {
        logic pllEnable;
        logic pllBypass;
        logic coreClkEn;
        logic sysClkEn;
        logic coreSupplyOn;
        logic dmaL1Allow;
    } pmc_ctl_t;

    typedef struct packed {
        logic eth;
        logic can;
        logic pin;
        logic rtc;
        logic rst;
    } pmc_wake_t;
endpackage

/* File: src/pmc_reg_step.sv */
// regulator level code to millivolt offset conversion
`timescale 1ns/10ps
module pmc_reg_step (
    input  wire logic [3:0]  levelCode,
    output logic      [9:0]  levelMv
);
    assign levelMv = 10'(levelCode * pmc_pkg::REG_STEP_MV);
endmodule // pmc_reg_step

/* File: src/pmc_wake_sync.sv */
// wake source conditioning: two-stage synchronisers and enable gating
`timescale 1ns/10ps
module pmc_wake_sync (
    input  wire logic              clk,
    input  wire logic              rstN,
    input  wire pmc_pkg::pmc_wake_t rawWake,
    input  wire logic [4:0]        wakeEnable,
    output pmc_pkg::pmc_wake_t     wakeEvt,
    output logic                   anyEnWake
);
    logic [4:0] meta_ff;
    logic [4:0] sync_ff;

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            meta_ff <= 5'h00;
            sync_ff <= 5'h00;
        end else begin
            meta_ff <= rawWake;
            sync_ff <= meta_ff;
        end
    end

    assign wakeEvt   = sync_ff;
    // the struct packs eth at its top bit, so line sources up with the enable order by name
    assign anyEnWake = |({wakeEvt.rst, wakeEvt.rtc, wakeEvt.pin, wakeEvt.can, wakeEvt.eth} & wakeEnable);
endmodule // pmc_wake_sync

/* File: src/power_mode_controller.sv */
// power mode controller: five operating states, clock gating, regulator control
`timescale 1ns/10ps
module power_mode_controller (
    input  wire logic        clk,
    input  wire logic        arst_n,
    input  wire logic [3:0]  regAddr,
    input  wire logic [15:0] regWdata,
    input  wire logic        regWr,
    input  wire logic        regRd,
    output logic      [15:0] regRdata,
    input  wire logic        ethWake,
    input  wire logic        canWake,
    input  wire logic        phy_interrupt_n,
    input  wire logic        rtcWake,
    input  wire logic        resetPinReq,
    input  wire logic        coreWake,
    output logic             pllEnable,
    output logic             pllBypass,
    output logic      [5:0]  pllMultiplier,
    output logic             coreClkEn,
    output logic             sysClkEn,
    output logic             coreSupplyOn,
    output logic             dmaL1Allow,
    output logic             pinOutEnable,
    output logic             sdramCkeLow,
    output logic      [3:0]  regLevel,
    output logic             regBypass,
    output logic             hwResetSeq
);
    logic        rstMeta_ff;
    logic        rstN;
    logic [15:0] pllCtl_ff;
    logic [15:0] vrCtl_ff;
    logic [5:0]  mselLive_ff;
    logic [3:0]  seqCnt_ff;
    logic        inReset_ff;
    logic        anyEnWake;
    logic        rstWake;
    logic [9:0]  levelMv;
    pmc_pkg::pmc_state_t state_ff;
    pmc_pkg::pmc_state_t nxt_state;
    pmc_pkg::pmc_ctl_t   ctl;
    pmc_pkg::pmc_wake_t  rawWake;
    pmc_pkg::pmc_wake_t  wakeEvt;

    // reset release through two flops
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rstMeta_ff <= 1'b0;
            rstN       <= 1'b0;
        end else begin
            rstMeta_ff <= 1'b1;
            rstN       <= rstMeta_ff;
        end
    end

    assign rawWake = '{eth: ethWake, can: canWake, pin: ~phy_interrupt_n, rtc: rtcWake, rst: resetPinReq};

    pmc_wake_sync u_wake (
        .clk        (clk),
        .rstN       (rstN),
        .rawWake    (rawWake),
        .wakeEnable (vrCtl_ff[pmc_pkg::VR_WAKE_LSB +: 5]),
        .wakeEvt    (wakeEvt),
        .anyEnWake  (anyEnWake)
    );

    pmc_reg_step u_step (
        .levelCode (vrCtl_ff[pmc_pkg::VR_LEVEL_LSB +: 4]),
        .levelMv   (levelMv)
    );

    function automatic logic hitWrite(input logic [3:0] a, input logic [3:0] off, input logic wr);
        hitWrite = wr && (a == off);
    endfunction

    assign rstWake = wakeEvt.rst;

    // pll control; lost on hibernate wake since the reset sequence reloads it
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            pllCtl_ff <= pmc_pkg::PLL_CONTROL_RESET;
        end else if (inReset_ff) begin
            pllCtl_ff <= pmc_pkg::PLL_CONTROL_RESET;
        end else if (hitWrite(regAddr, pmc_pkg::ADDR_PLL_CONTROL, regWr)) begin
            pllCtl_ff <= regWdata;
        end
    end

    // regulator control keeps its content across hibernate
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            vrCtl_ff <= pmc_pkg::REG_CONTROL_RESET;
        end else if (hitWrite(regAddr, pmc_pkg::ADDR_REG_CONTROL, regWr) && state_ff != pmc_pkg::ST_HIBER) begin
            vrCtl_ff <= regWdata;
        end
    end

    // the live multiplier only follows the register while in full-on
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            mselLive_ff <= pmc_pkg::MSEL_RESET;
        end else if (nxt_state == pmc_pkg::ST_FULLON) begin
            mselLive_ff <= pllCtl_ff[pmc_pkg::PLL_MSEL_LSB +: 6];
        end
    end

    // operating state machine
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            pmc_pkg::ST_FULLON, pmc_pkg::ST_ACTIVE: begin
                if (hitWrite(regAddr, pmc_pkg::ADDR_REG_CONTROL, regWr)
                    && regWdata[pmc_pkg::VR_RATE_LSB +: 2] == pmc_pkg::RATE_OFF) begin
                    nxt_state = pmc_pkg::ST_HIBER;
                end else if (hitWrite(regAddr, pmc_pkg::ADDR_MODE_REQ, regWr)) begin
                    case (regWdata[1:0])
                        pmc_pkg::REQ_SLEEP:  nxt_state = pmc_pkg::ST_SLEEP;
                        pmc_pkg::REQ_DEEP:   nxt_state = pmc_pkg::ST_DEEP;
                        pmc_pkg::REQ_ACTIVE: nxt_state = pmc_pkg::ST_ACTIVE;
                        default:             nxt_state = pmc_pkg::ST_FULLON;
                    endcase
                end
            end
            pmc_pkg::ST_SLEEP: begin
                if (coreWake || wakeEvt.rtc || wakeEvt.eth) begin
                    nxt_state = pllCtl_ff[pmc_pkg::PLL_BYPASS_BIT] ? pmc_pkg::ST_ACTIVE
                                                                    : pmc_pkg::ST_FULLON;
                end
            end
            pmc_pkg::ST_DEEP: begin
                if (rstWake) begin
                    nxt_state = pmc_pkg::ST_FULLON;
                end else if (wakeEvt.rtc) begin
                    nxt_state = pmc_pkg::ST_ACTIVE;
                end
            end
            pmc_pkg::ST_HIBER: begin
                if (anyEnWake) begin
                    nxt_state = pmc_pkg::ST_FULLON;
                end
            end
            default: nxt_state = pmc_pkg::ST_FULLON;
        endcase
    end

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            state_ff <= pmc_pkg::ST_FULLON;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // hardware reset sequence after a hibernate wake
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            seqCnt_ff  <= 4'h0;
            inReset_ff <= 1'b0;
        end else if (state_ff == pmc_pkg::ST_HIBER && anyEnWake) begin
            seqCnt_ff  <= pmc_pkg::RST_SEQ_CYCLES;
            inReset_ff <= 1'b1;
        end else if (seqCnt_ff != 4'h0) begin
            seqCnt_ff  <= seqCnt_ff - 4'h1;
            inReset_ff <= (seqCnt_ff != 4'h1);
        end
    end

    // clock and supply settings per state
    always_comb begin
        ctl = '0;
        case (nxt_state)
            pmc_pkg::ST_FULLON: begin
                ctl = '{pllEnable: 1'b1, pllBypass: 1'b0, coreClkEn: 1'b1, sysClkEn: 1'b1,
                        coreSupplyOn: 1'b1, dmaL1Allow: 1'b1};
            end
            pmc_pkg::ST_ACTIVE: begin
                ctl = '{pllEnable: ~pllCtl_ff[pmc_pkg::PLL_OFF_BIT], pllBypass: 1'b1, coreClkEn: 1'b1,
                        sysClkEn: 1'b1, coreSupplyOn: 1'b1, dmaL1Allow: 1'b1};
            end
            pmc_pkg::ST_SLEEP: begin
                ctl = '{pllEnable: 1'b1, pllBypass: pllCtl_ff[pmc_pkg::PLL_BYPASS_BIT], coreClkEn: 1'b0,
                        sysClkEn: 1'b1, coreSupplyOn: 1'b1, dmaL1Allow: 1'b0};
            end
            pmc_pkg::ST_DEEP: begin
                ctl = '{pllEnable: 1'b0, pllBypass: 1'b0, coreClkEn: 1'b0, sysClkEn: 1'b0,
                        coreSupplyOn: 1'b1, dmaL1Allow: 1'b0};
            end
            default: begin
                ctl = '0;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            pllEnable     <= 1'b1;
            pllBypass     <= 1'b0;
            coreClkEn     <= 1'b1;
            sysClkEn      <= 1'b1;
            coreSupplyOn  <= 1'b1;
            dmaL1Allow    <= 1'b1;
            pinOutEnable  <= 1'b1;
        end else begin
            pllEnable     <= ctl.pllEnable;
            pllBypass     <= ctl.pllBypass;
            coreClkEn     <= ctl.coreClkEn & ~inReset_ff;
            sysClkEn      <= ctl.sysClkEn;
            coreSupplyOn  <= ctl.coreSupplyOn;
            dmaL1Allow    <= ctl.dmaL1Allow & ~inReset_ff;
            pinOutEnable  <= (nxt_state != pmc_pkg::ST_HIBER);
        end
    end

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            pllMultiplier <= pmc_pkg::MSEL_RESET;
            sdramCkeLow   <= 1'b0;
            regLevel      <= 4'h0;
            regBypass     <= 1'b0;
            hwResetSeq    <= 1'b0;
        end else begin
            pllMultiplier <= mselLive_ff;
            // self-refresh hold while the core is in reset or powered down
            sdramCkeLow   <= vrCtl_ff[pmc_pkg::VR_SCKE_BIT] & (inReset_ff | state_ff == pmc_pkg::ST_HIBER);
            regLevel      <= vrCtl_ff[pmc_pkg::VR_LEVEL_LSB +: 4];
            regBypass     <= vrCtl_ff[pmc_pkg::VR_BYPASS_BIT];
            hwResetSeq    <= inReset_ff | (state_ff == pmc_pkg::ST_HIBER && anyEnWake);
        end
    end

    // read port, data one cycle after the strobe
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            regRdata <= 16'h0000;
        end else if (!regRd) begin
            regRdata <= 16'h0000;
        end else if (regAddr == pmc_pkg::ADDR_PLL_CONTROL) begin
            regRdata <= pllCtl_ff;
        end else if (regAddr == pmc_pkg::ADDR_REG_CONTROL) begin
            regRdata <= vrCtl_ff;
        end else if (regAddr == pmc_pkg::ADDR_STATUS) begin
            regRdata <= {levelMv, inReset_ff, wakeEvt.rtc, 1'b0, state_ff};
        end else begin
            regRdata <= 16'h0000;
        end
    end

    chk_sleep_wake_bypass: assert property (@(posedge clk) disable iff (!rstN)
        state_ff == pmc_pkg::ST_SLEEP && nxt_state != pmc_pkg::ST_SLEEP |=>
        state_ff == (pllCtl_ff[pmc_pkg::PLL_BYPASS_BIT] ? pmc_pkg::ST_ACTIVE : pmc_pkg::ST_FULLON))
        else $error("sleep wake target wrong");
    chk_fullon_clocks: assert property (@(posedge clk) disable iff (!rstN)
        state_ff == pmc_pkg::ST_FULLON |-> pllEnable && !pllBypass && sysClkEn)
        else $error("full-on clocks wrong");
    chk_sleep_core_off: assert property (@(posedge clk) disable iff (!rstN)
        state_ff == pmc_pkg::ST_SLEEP |-> !coreClkEn && sysClkEn && !dmaL1Allow)
        else $error("sleep gating wrong");
    chk_deep_all_off: assert property (@(posedge clk) disable iff (!rstN)
        state_ff == pmc_pkg::ST_DEEP |-> !pllEnable && !coreClkEn && !sysClkEn)
        else $error("deep sleep clocks running");
    chk_hiber_pins_off: assert property (@(posedge clk) disable iff (!rstN)
        state_ff == pmc_pkg::ST_HIBER |-> !pinOutEnable && !coreSupplyOn)
        else $error("hibernate pins or supply on");
    chk_hiber_wake_seq: assert property (@(posedge clk) disable iff (!rstN)
        state_ff == pmc_pkg::ST_HIBER && anyEnWake |=> hwResetSeq ##1 hwResetSeq)
        else $error("hibernate wake without reset sequence");
    chk_req_from_run: assert property (@(posedge clk) disable iff (!rstN)
        $changed(state_ff) && state_ff inside {pmc_pkg::ST_SLEEP, pmc_pkg::ST_DEEP, pmc_pkg::ST_HIBER} |->
        $past(state_ff) inside {pmc_pkg::ST_FULLON, pmc_pkg::ST_ACTIVE})
        else $error("low power entry from wrong state");
    chk_active_bypass: assert property (@(posedge clk) disable iff (!rstN)
        state_ff == pmc_pkg::ST_ACTIVE |-> pllBypass && coreClkEn && dmaL1Allow)
        else $error("active mode settings wrong");
endmodule // power_mode_controller

/* File: testbench/pmc_wake_model.sv */
// wake and reset source model standing outside the power mode controller
`timescale 1ns/10ps
module pmc_wake_model (
    input  wire logic       clk,
    input  wire logic [5:0] wakeReq,
    output logic            ethWake,
    output logic            canWake,
    output logic            phy_interrupt_n,
    output logic            rtcWake,
    output logic            resetPinReq,
    output logic            coreWake
);
    // wake pin idles at its pull-up level; low only while that source is requested
    initial begin
        {ethWake, canWake, rtcWake, resetPinReq, coreWake} = 5'h00;
        phy_interrupt_n = 1'b1;
    end

    // sources change only just after an edge, held as levels until withdrawn
    always @(posedge clk) begin
        ethWake         <= wakeReq[0];
        canWake         <= wakeReq[1];
        phy_interrupt_n <= ~wakeReq[2];
        rtcWake         <= wakeReq[3];
        resetPinReq     <= wakeReq[4];
        coreWake        <= wakeReq[5];
    end
endmodule // pmc_wake_model

/* File: testbench/power_mode_controller_tb_top.sv */
// self-checking bench for the power mode controller
`timescale 1ns/10ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin errors++; \
    $display("wrong value t=%0t got %h exp %h", $time, (a), (b)); end end
module power_mode_controller_tb_top;
    logic        clk      = 1'b0;
    logic        arst_n   = 1'b0;
    logic [3:0]  regAddr  = 4'h0;
    logic [15:0] regWdata = 16'h0000;
    logic        regWr    = 1'b0;
    logic        regRd    = 1'b0;
    logic [5:0]  wakeReq  = 6'h00;
    logic [15:0] regRdata;
    logic        ethWake, canWake, phy_interrupt_n, rtcWake, resetPinReq, coreWake;
    logic        pllEnable, pllBypass, coreClkEn, sysClkEn, coreSupplyOn, dmaL1Allow;
    logic        pinOutEnable, sdramCkeLow, regBypass, hwResetSeq;
    logic [5:0]  pllMultiplier;
    logic [3:0]  regLevel;
    int          errors   = 0;
    int          compares = 0;

    always #5 clk = ~clk;

    pmc_wake_model partner (.clk(clk), .wakeReq(wakeReq), .ethWake(ethWake), .canWake(canWake),
        .phy_interrupt_n(phy_interrupt_n), .rtcWake(rtcWake), .resetPinReq(resetPinReq), .coreWake(coreWake));

    power_mode_controller DUT (.clk(clk), .arst_n(arst_n), .regAddr(regAddr), .regWdata(regWdata),
        .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .ethWake(ethWake), .canWake(canWake),
        .phy_interrupt_n(phy_interrupt_n), .rtcWake(rtcWake), .resetPinReq(resetPinReq),
        .coreWake(coreWake), .pllEnable(pllEnable), .pllBypass(pllBypass), .pllMultiplier(pllMultiplier),
        .coreClkEn(coreClkEn), .sysClkEn(sysClkEn), .coreSupplyOn(coreSupplyOn), .dmaL1Allow(dmaL1Allow),
        .pinOutEnable(pinOutEnable), .sdramCkeLow(sdramCkeLow), .regLevel(regLevel),
        .regBypass(regBypass), .hwResetSeq(hwResetSeq));

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        regAddr  <= a;
        regWdata <= d;
        regWr    <= 1'b1;
        @(posedge clk);
        regWr    <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk);
        regAddr <= a;
        regRd   <= 1'b1;
        @(posedge clk);
        regRd   <= 1'b0;
        #1 d = regRdata;
    endtask

    task automatic mode(input logic [1:0] r);
        wr(pmc_pkg::ADDR_MODE_REQ, {14'h0000, r});
    endtask

    // outputs follow one edge after the write; look a little after the next edge
    task automatic settle;
        @(posedge clk);
        #1;
    endtask

    task automatic src(input logic [5:0] v);
        @(posedge clk);
        wakeReq <= v;
    endtask

    // wake inputs cross two sync flops, so poll status under a bound
    task automatic wait_state(input pmc_pkg::pmc_state_t s);
        logic [15:0] d;
        int          n = 0;
        rd(pmc_pkg::ADDR_STATUS, d);
        while (d[2:0] !== s && n < 40) begin
            rd(pmc_pkg::ADDR_STATUS, d);
            n++;
        end
        `CHK(d[2:0], s)
    endtask

    task automatic t_reset;
        logic [15:0] d;
        `CHK({pllEnable, pllBypass, coreClkEn, sysClkEn, coreSupplyOn, pinOutEnable}, 6'b101111)
        `CHK(pllMultiplier, pmc_pkg::MSEL_RESET)
        rd(pmc_pkg::ADDR_PLL_CONTROL, d);
        `CHK(d, pmc_pkg::PLL_CONTROL_RESET)
        rd(pmc_pkg::ADDR_REG_CONTROL, d);
        `CHK(d, pmc_pkg::REG_CONTROL_RESET)
        rd(pmc_pkg::ADDR_STATUS, d);
        `CHK(d[2:0], pmc_pkg::ST_FULLON)
        rd(4'h2, d);
        `CHK(d, 16'h0000)
    endtask

    task automatic t_active;
        mode(pmc_pkg::REQ_ACTIVE);
        settle;
        `CHK({pllEnable, pllBypass, coreClkEn, sysClkEn, dmaL1Allow}, 5'b11111)
        wr(pmc_pkg::ADDR_PLL_CONTROL, 16'h1402);
        settle;
        `CHK(pllMultiplier, pmc_pkg::MSEL_RESET)
        `CHK(pllEnable, 1'b0)
        wr(pmc_pkg::ADDR_PLL_CONTROL, 16'h1400);
        mode(2'h0);
        settle;
        `CHK(pllMultiplier, 6'h14)
        `CHK({pllEnable, pllBypass, coreClkEn}, 3'b101)
    endtask

    task automatic t_sleep;
        for (int b = 0; b < 2; b++) begin
            if (b == 1)
                mode(pmc_pkg::REQ_ACTIVE);
            wr(pmc_pkg::ADDR_PLL_CONTROL, 16'h1400 | 16'(b));
            mode(pmc_pkg::REQ_SLEEP);
            settle;
            `CHK({pllEnable, coreClkEn, sysClkEn, dmaL1Allow}, 4'b1010)
            mode(pmc_pkg::REQ_DEEP);
            wait_state(pmc_pkg::ST_SLEEP);
            src(6'h20);
            wait_state(b == 1 ? pmc_pkg::ST_ACTIVE : pmc_pkg::ST_FULLON);
            src(6'h00);
        end
    endtask

    task automatic t_deep;
        for (int k = 0; k < 2; k++) begin
            mode(pmc_pkg::REQ_DEEP);
            settle;
            `CHK({pllEnable, coreClkEn, sysClkEn, coreSupplyOn}, 4'b0001)
            src(6'h23);
            repeat (8) @(posedge clk);
            wait_state(pmc_pkg::ST_DEEP);
            src(k == 1 ? 6'h10 : 6'h08);
            wait_state(k == 1 ? pmc_pkg::ST_FULLON : pmc_pkg::ST_ACTIVE);
            src(6'h00);
            // let the withdrawn source drain through the model and sync flops before deep sleep again
            repeat (4) @(posedge clk);
        end
    endtask

    task automatic t_level;
        logic [15:0] d;
        for (int c = 8; c < 10; c++) begin
            wr(pmc_pkg::ADDR_REG_CONTROL, 16'h4003 | 16'(c << 4));
            settle;
            `CHK(regLevel, 4'(c))
            `CHK(regBypass, 1'b1)
            rd(pmc_pkg::ADDR_STATUS, d);
            `CHK(d[15:6], 10'(c * pmc_pkg::REG_STEP_MV))
        end
        wr(pmc_pkg::ADDR_REG_CONTROL, pmc_pkg::REG_CONTROL_RESET);
    endtask

    // one pass per wake source: a disabled source first, then the enabled one
    task automatic t_hiber;
        logic [15:0] d;
        logic [15:0] v;
        int          n;
        for (int i = 0; i < 5; i++) begin
            v = 16'h2090 | (16'h0100 << i);
            wr(pmc_pkg::ADDR_REG_CONTROL, v);
            settle;
            `CHK({coreSupplyOn, coreClkEn, sysClkEn, pllEnable, pinOutEnable}, 5'b00000)
            wr(pmc_pkg::ADDR_REG_CONTROL, pmc_pkg::REG_CONTROL_RESET);
            src(6'h01 << ((i + 1) % 5));
            repeat (8) @(posedge clk);
            #1;
            `CHK(coreSupplyOn, 1'b0)
            src(6'h01 << i);
            n = 0;
            while (hwResetSeq !== 1'b1 && n < 40) begin
                @(posedge clk);
                #1;
                n++;
            end
            `CHK(hwResetSeq, 1'b1)
            `CHK(sdramCkeLow, 1'b1)
            src(6'h00);
            wait_state(pmc_pkg::ST_FULLON);
            rd(pmc_pkg::ADDR_REG_CONTROL, d);
            `CHK(d, v)
            rd(pmc_pkg::ADDR_PLL_CONTROL, d);
            `CHK(d, pmc_pkg::PLL_CONTROL_RESET)
        end
    endtask

    task automatic stop_test;
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    initial begin
        repeat (6) @(posedge clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
        t_reset;
        t_active;
        t_sleep;
        t_deep;
        t_level;
        t_hiber;
        stop_test;
    end

    // the whole sequence needs a few hundred cycles; this bound cuts a hang
    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        stop_test;
    end
endmodule // power_mode_controller_tb_top
